// ===== core/asp_pin_map.vh
// Constants for the audio serial pin logic
`ifndef ASP_PIN_MAP_VH
`define ASP_PIN_MAP_VH

// ==========================================================================
// Pin indices in the pin vectors
`define ASP_NPINS        5
`define ASP_PIN_RX_HF    0
`define ASP_PIN_TX_HF    1
`define ASP_PIN_RX_FS    2
`define ASP_PIN_TX_FS    3
`define ASP_PIN_TX_BCLK  4

// ==========================================================================
// Port-use mode, two bits per pin
`define ASP_PM_W         2
`define ASP_PM_OFF       2'h0
`define ASP_PM_IN        2'h1
`define ASP_PM_OUT       2'h2

// ==========================================================================
// Serial-use pin direction
`define ASP_DIR_IN       1'h0
`define ASP_DIR_OUT      1'h1

// ==========================================================================
// High-frequency clock divider
`define ASP_HF_DIV_W     4
`define ASP_HF_DIV_RST   4'h0

// ==========================================================================
// Reset values
`define ASP_PINS_RST     5'h00
`define ASP_PM_ALL_RST   10'h000
`define ASP_BIT_RST      1'h0

`endif

// ===== core/asp_pin_mux.v
// Clock, frame-sync and serial-flag pin logic of the audio serial unit
`timescale 1ns/100ps
// ==========================================================================
// Overview of operation
// RULE1: rx hf pin input clocks receiver
// RULE2: rx hf pin output drives hf clock
// RULE3: tx hf pin input clocks transmitter
// RULE4: tx hf pin output drives hf clock
// RULE5: port use: each pin in, out, off
// RULE6: reset leaves all pins port-disconnected
// RULE7: async: rx frame pin is receiver sync
// RULE8: sync without buffer select: flag one
// RULE9: sync, buffer select, out: buffer enable
// RULE10: flag direction follows rx frame direction
// RULE11: flag output shows out_flag_one value
// RULE12: flag output updates on frame or slot
// RULE13: flag input captured on frame or slot
// RULE14: sync: tx frame pin syncs both sections
// RULE15: async: tx frame pin syncs transmitters
// RULE16: tx frame direction from tx_frame_sync_dir
// RULE17: tx bit clock for tx, rx if sync
// RULE18: disconnected pin: no drive, input ignored
`include "asp_pin_map.vh"

module asp_pin_mux (
	input  wire                      clock,                   // Core clock, 20 MHz
	input  wire                      rstn,                    // Synchronous reset, active low
	input  wire                      ce,                      // Clock enable, freezes all state
	// Configuration from the control registers
	input  wire                      serial_use,              // 1: serial use, 0: port use
	input  wire                      sync_mode_select,        // 1: synchronous operation
	input  wire                      tx_buffer_enable_select, // Buffer enable on rx frame pin
	input  wire                      rx_frame_sync_dir,       // rx frame pin direction, 1 out
	input  wire                      tx_frame_sync_dir,       // tx frame pin direction, 1 out
	input  wire                      rx_hf_clock_dir,         // rx hf pin direction, 1 out
	input  wire                      tx_hf_clock_dir,         // tx hf pin direction, 1 out
	input  wire                      tx_bit_clock_dir,        // tx bit clock direction, 1 out
	input  wire                      network_mode,            // 1: network (slot) operation
	input  wire                      out_flag_one,            // Output flag one value
	input  wire [`ASP_HF_DIV_W-1:0]  rx_hf_div,               // rx hf half period minus one
	input  wire [`ASP_HF_DIV_W-1:0]  tx_hf_div,               // tx hf half period minus one
	input  wire [2*`ASP_NPINS-1:0]   port_mode,               // Two mode bits per pin
	input  wire [`ASP_NPINS-1:0]     port_out,                // Port output data per pin
	// Serial section signals on the core clock
	input  wire                      rx_fs_gen,               // Receiver frame sync, generated
	input  wire                      tx_fs_gen,               // Transmitter frame sync, generated
	input  wire                      tx_bclk_gen,             // Transmit bit clock, generated
	input  wire                      slot_strobe,             // One pulse per slot
	input  wire                      tx_buf_enable,           // External buffer enable level
	// Results to the serial section and status registers
	output reg                       rx_hf_tick,              // Receiver hf clock tick
	output reg                       tx_hf_tick,              // Transmitter hf clock tick
	output reg                       rx_frame_event,          // Receiver frame sync pulse
	output reg                       tx_frame_event,          // Transmitter frame sync pulse
	output reg                       tx_bclk_rise,            // Transmit bit clock rise pulse
	output reg                       rx_bclk_rise,            // Receive bit clock rise, sync only
	output reg                       in_flag_one,             // Captured input flag one
	output reg  [`ASP_NPINS-1:0]     port_in,                 // Port input data per pin
	// Pins
	input  wire                      rx_hf_clock_pin_in,      // rx hf clock pin level
	output wire                      rx_hf_clock_pin_out,     // rx hf clock pin drive value
	output wire                      rx_hf_clock_pin_oe,      // rx hf clock pin driven
	input  wire                      tx_hf_clock_pin_in,      // tx hf clock pin level
	output wire                      tx_hf_clock_pin_out,     // tx hf clock pin drive value
	output wire                      tx_hf_clock_pin_oe,      // tx hf clock pin driven
	input  wire                      rx_frame_sync_pin_in,    // rx frame sync pin level
	output wire                      rx_frame_sync_pin_out,   // rx frame sync pin drive value
	output wire                      rx_frame_sync_pin_oe,    // rx frame sync pin driven
	input  wire                      tx_frame_sync_pin_in,    // tx frame sync pin level
	output wire                      tx_frame_sync_pin_out,   // tx frame sync pin drive value
	output wire                      tx_frame_sync_pin_oe,    // tx frame sync pin driven
	input  wire                      tx_bit_clock_pin_in,     // tx bit clock pin level
	output wire                      tx_bit_clock_pin_out,    // tx bit clock pin drive value
	output wire                      tx_bit_clock_pin_oe      // tx bit clock pin driven
);

	// ======================================================================
	// Pin vectors
	wire [`ASP_NPINS-1:0]   pin_raw;
	reg  [`ASP_NPINS-1:0]   pin_out_q;
	reg  [`ASP_NPINS-1:0]   pin_oe_q;
	reg  [`ASP_NPINS-1:0]   sync1_q;
	reg  [`ASP_NPINS-1:0]   sync2_q;
	reg  [`ASP_NPINS-1:0]   prev_q;
	reg  [`ASP_NPINS-1:0]   ser_oe;
	reg  [`ASP_NPINS-1:0]   ser_out;
	wire [`ASP_NPINS-1:0]   in_en;
	wire [`ASP_NPINS-1:0]   pin_lvl;
	wire [`ASP_NPINS-1:0]   pin_rise;

	assign pin_raw = {tx_bit_clock_pin_in, tx_frame_sync_pin_in, rx_frame_sync_pin_in,
		tx_hf_clock_pin_in, rx_hf_clock_pin_in};

	assign rx_hf_clock_pin_out   = pin_out_q[`ASP_PIN_RX_HF];
	assign rx_hf_clock_pin_oe    = pin_oe_q[`ASP_PIN_RX_HF];
	assign tx_hf_clock_pin_out   = pin_out_q[`ASP_PIN_TX_HF];
	assign tx_hf_clock_pin_oe    = pin_oe_q[`ASP_PIN_TX_HF];
	assign rx_frame_sync_pin_out = pin_out_q[`ASP_PIN_RX_FS];
	assign rx_frame_sync_pin_oe  = pin_oe_q[`ASP_PIN_RX_FS];
	assign tx_frame_sync_pin_out = pin_out_q[`ASP_PIN_TX_FS];
	assign tx_frame_sync_pin_oe  = pin_oe_q[`ASP_PIN_TX_FS];
	assign tx_bit_clock_pin_out  = pin_out_q[`ASP_PIN_TX_BCLK];
	assign tx_bit_clock_pin_oe   = pin_oe_q[`ASP_PIN_TX_BCLK];

	// ======================================================================
	// Configuration capture
	// Serial use and port mode pass flops so reset alone sets the pin state,
	// whatever the config ports show in reset.
	reg                        serial_q;
	reg  [2*`ASP_NPINS-1:0]    mode_q;

	always @(posedge clock) begin
		if (!rstn) begin
			serial_q <= `ASP_BIT_RST;          // see RULE6
			mode_q   <= `ASP_PM_ALL_RST;       // see RULE6
		end else if (ce) begin
			serial_q <= serial_use;
			mode_q   <= port_mode;
		end
	end

	// ======================================================================
	// High-frequency clock dividers
	reg  [`ASP_HF_DIV_W-1:0]  rx_hf_cnt_q;
	reg  [`ASP_HF_DIV_W-1:0]  tx_hf_cnt_q;
	reg                       rx_hf_q;
	reg                       tx_hf_q;

	// Divided core clock, toggled when the count reaches the divisor
	always @(posedge clock) begin
		if (!rstn) begin
			rx_hf_cnt_q <= `ASP_HF_DIV_RST;
			tx_hf_cnt_q <= `ASP_HF_DIV_RST;
			rx_hf_q     <= `ASP_BIT_RST;
			tx_hf_q     <= `ASP_BIT_RST;
		end else if (ce) begin
			if (rx_hf_cnt_q >= rx_hf_div) begin
				rx_hf_cnt_q <= `ASP_HF_DIV_RST;
				rx_hf_q     <= ~rx_hf_q;         // see RULE2
			end else begin
				rx_hf_cnt_q <= rx_hf_cnt_q + 1'b1;
			end
			if (tx_hf_cnt_q >= tx_hf_div) begin
				tx_hf_cnt_q <= `ASP_HF_DIV_RST;
				tx_hf_q     <= ~tx_hf_q;         // see RULE4
			end else begin
				tx_hf_cnt_q <= tx_hf_cnt_q + 1'b1;
			end
		end
	end

	// ======================================================================
	// Output flag one register
	reg                       flag_out_q;
	wire                      flag_mode;
	wire                      flag_strobe;

	assign flag_mode = sync_mode_select & ~tx_buffer_enable_select;   // see RULE8

	// ======================================================================
	// Serial-use direction and drive per pin
	always @* begin
		ser_oe  = `ASP_PINS_RST;
		ser_out = `ASP_PINS_RST;
		ser_oe[`ASP_PIN_RX_HF]    = rx_hf_clock_dir;                  // see RULE2
		ser_out[`ASP_PIN_RX_HF]   = rx_hf_q;
		ser_oe[`ASP_PIN_TX_HF]    = tx_hf_clock_dir;                  // see RULE4
		ser_out[`ASP_PIN_TX_HF]   = tx_hf_q;
		ser_oe[`ASP_PIN_TX_FS]    = tx_frame_sync_dir;                // see RULE16
		ser_out[`ASP_PIN_TX_FS]   = tx_fs_gen;
		ser_oe[`ASP_PIN_TX_BCLK]  = tx_bit_clock_dir;                 // see RULE17
		ser_out[`ASP_PIN_TX_BCLK] = tx_bclk_gen;
		if (!sync_mode_select) begin
			ser_oe[`ASP_PIN_RX_FS]  = rx_frame_sync_dir;              // see RULE7
			ser_out[`ASP_PIN_RX_FS] = rx_fs_gen;
		end else if (!tx_buffer_enable_select) begin
			ser_oe[`ASP_PIN_RX_FS]  = rx_frame_sync_dir;              // see RULE10
			ser_out[`ASP_PIN_RX_FS] = flag_out_q;                     // see RULE11
		end else if (rx_frame_sync_dir) begin
			ser_oe[`ASP_PIN_RX_FS]  = `ASP_DIR_OUT;                   // see RULE9
			ser_out[`ASP_PIN_RX_FS] = tx_buf_enable;
		end else begin
			// Buffer select with input direction: pin stays quiet
			ser_oe[`ASP_PIN_RX_FS]  = `ASP_DIR_IN;
			ser_out[`ASP_PIN_RX_FS] = `ASP_BIT_RST;
		end
	end

	// ======================================================================
	// Per-pin synchroniser, input gating and port-use drive
	genvar gi;
	generate
		for (gi = 0; gi < `ASP_NPINS; gi = gi + 1) begin : g_pin
			wire [`ASP_PM_W-1:0] mode_w;
			assign mode_w = mode_q[gi*`ASP_PM_W +: `ASP_PM_W];

			// Serial use listens only when not driving; port use only in IN mode
			assign in_en[gi] = serial_q ? ~ser_oe[gi] : (mode_w == `ASP_PM_IN);  // see RULE18

			// Pins are asynchronous: two flops before any use
			always @(posedge clock) begin
				if (!rstn) begin
					sync1_q[gi] <= `ASP_BIT_RST;
					sync2_q[gi] <= `ASP_BIT_RST;
					prev_q[gi]  <= `ASP_BIT_RST;
				end else if (ce) begin
					sync1_q[gi] <= pin_raw[gi];
					sync2_q[gi] <= sync1_q[gi];
					prev_q[gi]  <= pin_lvl[gi];
				end
			end

			assign pin_lvl[gi]  = sync2_q[gi] & in_en[gi];            // see RULE18
			assign pin_rise[gi] = pin_lvl[gi] & ~prev_q[gi];

			// Registered pin drive; OFF mode keeps the driver off
			always @(posedge clock) begin
				if (!rstn) begin
					pin_oe_q[gi]  <= `ASP_BIT_RST;                    // see RULE6
					pin_out_q[gi] <= `ASP_BIT_RST;
					port_in[gi]   <= `ASP_BIT_RST;
				end else if (ce) begin
					if (serial_q) begin
						pin_oe_q[gi]  <= ser_oe[gi];
						pin_out_q[gi] <= ser_out[gi];
						port_in[gi]   <= `ASP_BIT_RST;
					end else begin
						pin_oe_q[gi]  <= (mode_w == `ASP_PM_OUT);     // see RULE5
						pin_out_q[gi] <= port_out[gi] & (mode_w == `ASP_PM_OUT);
						port_in[gi]   <= pin_lvl[gi];                 // see RULE5
					end
				end
			end
		end
	endgenerate

	// ======================================================================
	// Edge detection on generated frame sync and bit clock
	reg                       tx_fs_gen_q;
	reg                       rx_fs_gen_q;
	reg                       tx_bclk_gen_q;
	wire                      tx_fs_ev;
	wire                      rx_fs_ev;
	wire                      bclk_ev;

	always @(posedge clock) begin
		if (!rstn) begin
			tx_fs_gen_q   <= `ASP_BIT_RST;
			rx_fs_gen_q   <= `ASP_BIT_RST;
			tx_bclk_gen_q <= `ASP_BIT_RST;
		end else if (ce) begin
			tx_fs_gen_q   <= tx_fs_gen;
			rx_fs_gen_q   <= rx_fs_gen;
			tx_bclk_gen_q <= tx_bclk_gen;
		end
	end

	// Frame sync from the pin as input, else from the generator
	assign tx_fs_ev = serial_q & (tx_frame_sync_dir ? (tx_fs_gen & ~tx_fs_gen_q)
		: pin_rise[`ASP_PIN_TX_FS]);                                  // see RULE16
	assign rx_fs_ev = serial_q & (rx_frame_sync_dir ? (rx_fs_gen & ~rx_fs_gen_q)
		: pin_rise[`ASP_PIN_RX_FS]);
	assign bclk_ev  = serial_q & (tx_bit_clock_dir ? (tx_bclk_gen & ~tx_bclk_gen_q)
		: pin_rise[`ASP_PIN_TX_BCLK]);

	// Flags follow frame sync, or each slot in network use
	assign flag_strobe = network_mode ? slot_strobe : tx_fs_ev;       // see RULE12

	// ======================================================================
	// Event outputs toward the serial sections
	// Core clock unless the hf pin is an input; then pin edges count
	always @(posedge clock) begin
		if (!rstn) begin
			rx_hf_tick     <= `ASP_BIT_RST;
			tx_hf_tick     <= `ASP_BIT_RST;
			rx_frame_event <= `ASP_BIT_RST;
			tx_frame_event <= `ASP_BIT_RST;
			tx_bclk_rise   <= `ASP_BIT_RST;
			rx_bclk_rise   <= `ASP_BIT_RST;
		end else if (ce) begin
			rx_hf_tick <= (serial_q && !rx_hf_clock_dir) ?
				pin_rise[`ASP_PIN_RX_HF] : 1'b1;                      // see RULE1
			tx_hf_tick <= (serial_q && !tx_hf_clock_dir) ?
				pin_rise[`ASP_PIN_TX_HF] : 1'b1;                      // see RULE3
			tx_frame_event <= tx_fs_ev;                               // see RULE15
			// Sync use: receivers share the tx frame sync
			rx_frame_event <= sync_mode_select ? tx_fs_ev : rx_fs_ev;  // see RULE14
			tx_bclk_rise   <= bclk_ev;                                // see RULE17
			rx_bclk_rise   <= sync_mode_select & bclk_ev;             // see RULE17
		end
	end

	// ======================================================================
	// Serial flag one: output value and captured input
	// Output copy moves only on a strobe, so the pin follows the frame
	always @(posedge clock) begin
		if (!rstn) begin
			flag_out_q  <= `ASP_BIT_RST;
			in_flag_one <= `ASP_BIT_RST;
		end else if (ce) begin
			if (flag_strobe && serial_q && flag_mode) begin
				if (rx_frame_sync_dir) begin
					flag_out_q <= out_flag_one;                       // see RULE12
				end else begin
					in_flag_one <= pin_lvl[`ASP_PIN_RX_FS];           // see RULE13
				end
			end
		end
	end

endmodule

// ===== dv/asp_codec_model.sv
// Far-side converter model on the clock, frame and flag pins
`timescale 1ns/100ps
module asp_codec_model (
	input  wire       link_on, // Run the hf link clock
	input  wire [4:0] drv_en,  // Converter drives pin
	input  wire [4:0] drv_val, // Converter drive level
	input  wire [4:0] oe,      // Block drives pin
	input  wire [4:0] dout,    // Block drive level
	output wire [4:0] pin      // Resolved pin level
);
	// ==========================================================================
	// 400 ns link clock, unrelated phase, frozen when off
	reg        lclk;
	reg        junk;
	wire [4:0] hf = {3'h0, {2{link_on}}};
	initial begin
		lclk = 1'b0;
		#13;
		forever #200 lclk = link_on ? ~lclk : lclk;
	end
	// Floating pins wander so stale levels never pass
	initial begin
		junk = 1'b0;
		forever #37 junk = ~junk;
	end
	// Block first, then converter, then hf link, else noise
	assign pin = (oe & dout) | (~oe & drv_en & drv_val)
		| (~oe & ~drv_en & hf & {5{lclk}}) | (~oe & ~drv_en & ~hf & {5{junk}});
endmodule

// ===== dv/asp_pin_mux_sva.sv
// Assertion checker on the audio serial pin ports
`timescale 1ns/100ps
`include "asp_pin_map.vh"
module asp_pin_mux_sva (
	input wire                     clock,                   // Core clock
	input wire                     rstn,                    // Reset, active low
	input wire                     serial_use,              // Serial or port use
	input wire                     sync_mode_select,        // Synchronous operation
	input wire                     tx_buffer_enable_select, // Buffer enable select
	input wire                     rx_frame_sync_dir,       // rx frame direction
	input wire                     tx_frame_sync_dir,       // tx frame direction
	input wire                     rx_hf_clock_dir,         // rx hf direction
	input wire                     tx_hf_clock_dir,         // tx hf direction
	input wire                     network_mode,            // Slot operation
	input wire                     out_flag_one,            // Output flag value
	input wire [`ASP_HF_DIV_W-1:0] tx_hf_div,               // tx hf divider
	input wire [2*`ASP_NPINS-1:0]  port_mode,               // Port modes
	input wire [`ASP_NPINS-1:0]    port_out,                // Port output data
	input wire                     slot_strobe,             // Slot pulse
	input wire                     tx_buf_enable,           // Buffer enable level
	input wire                     rx_hf_tick,              // rx hf tick
	input wire                     in_flag_one,             // Input flag
	input wire [`ASP_NPINS-1:0]    port_in,                 // Port input data
	input wire                     rx_hf_clock_pin_in,      // rx hf pin level
	input wire                     tx_hf_clock_pin_out,     // tx hf pin value
	input wire                     rx_frame_sync_pin_in,    // rx frame pin level
	input wire                     rx_frame_sync_pin_out,   // rx frame pin value
	input wire                     rx_frame_sync_pin_oe,    // rx frame pin driven
	input wire                     tx_frame_sync_pin_out,   // tx frame pin value
	input wire                     tx_frame_sync_pin_oe     // tx frame pin driven
);
	// ==========================================================================
	// rx frame pin in flag mode
	wire flag_cfg = serial_use && sync_mode_select && !tx_buffer_enable_select;
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);
	// ==========================================================================
	// Reset and port use; config reaches the pins two cycles late
	reset_pins_off_a: assert property (disable iff (1'b0)
		!rstn |=> !rx_frame_sync_pin_oe && !tx_frame_sync_pin_oe && port_in == 5'h00)
		else $error("pin active after reset");
	port_off_quiet_a: assert property (
		(!serial_use && port_mode[7:6] != `ASP_PM_OUT)[*2] |=> !tx_frame_sync_pin_oe)
		else $error("tx frame pin driven");
	port_drive_a: assert property ((!serial_use && port_mode[7:6] == `ASP_PM_OUT)[*2]
		|=> tx_frame_sync_pin_oe && tx_frame_sync_pin_out == $past(port_out[3]))
		else $error("port output wrong");
	port_in_mask_a: assert property (
		(!serial_use && port_mode[1:0] != `ASP_PM_IN)[*2] |=> port_in[0] == 1'b0)
		else $error("port input not masked");
	// ==========================================================================
	// Serial use checks
	tx_fs_dir_a: assert property (serial_use[*2] ##0 $stable(tx_frame_sync_dir)
		|=> tx_frame_sync_pin_oe == $past(tx_frame_sync_dir))
		else $error("tx frame pin direction wrong");
	flag_out_a: assert property (
		(flag_cfg && rx_frame_sync_dir)[*2] ##0 (network_mode && slot_strobe)
		##1 (flag_cfg && rx_frame_sync_dir)
		|=> rx_frame_sync_pin_oe && rx_frame_sync_pin_out == $past(out_flag_one, 2))
		else $error("output flag wrong");
	flag_in_a: assert property (
		(flag_cfg && !rx_frame_sync_dir && $stable(rx_frame_sync_pin_in))[*4]
		##0 (network_mode && slot_strobe)
		|=> in_flag_one == $past(rx_frame_sync_pin_in) && !rx_frame_sync_pin_oe)
		else $error("input flag wrong");
	buf_enable_a: assert property (
		(serial_use && sync_mode_select && tx_buffer_enable_select && rx_frame_sync_dir)[*2]
		|=> rx_frame_sync_pin_oe && rx_frame_sync_pin_out == $past(tx_buf_enable))
		else $error("buffer enable not driven");
	hf_toggle_a: assert property (
		(serial_use && tx_hf_clock_dir && tx_hf_div == 4'h1)[*4] ##0 $changed(tx_hf_clock_pin_out)
		|=> $stable(tx_hf_clock_pin_out) ##1 $changed(tx_hf_clock_pin_out))
		else $error("tx hf clock period wrong");
	hf_in_tick_a: assert property (
		(serial_use && !rx_hf_clock_dir)[*4] ##0 $rose(rx_hf_clock_pin_in) |-> ##3 rx_hf_tick)
		else $error("rx hf tick missing");
endmodule

// ===== dv/tb_top.sv
// Self-checking testbench for the audio serial pin logic
`timescale 1ns/100ps
bind asp_pin_mux asp_pin_mux_sva i_sva (.clock, .rstn, .serial_use, .sync_mode_select,
	.tx_buffer_enable_select, .rx_frame_sync_dir, .tx_frame_sync_dir, .rx_hf_clock_dir,
	.tx_hf_clock_dir, .network_mode, .out_flag_one, .tx_hf_div, .port_mode, .port_out,
	.slot_strobe, .tx_buf_enable, .rx_hf_tick, .in_flag_one, .port_in, .rx_hf_clock_pin_in,
	.tx_hf_clock_pin_out, .rx_frame_sync_pin_in, .rx_frame_sync_pin_out,
	.rx_frame_sync_pin_oe, .tx_frame_sync_pin_out, .tx_frame_sync_pin_oe);
module tb_top;
	// ==========================================================================
	// Stimulus and pins
	reg        clock, rstn, ce, clr, serial_use, sync_mode_select, tx_buffer_enable_select;
	reg        rx_frame_sync_dir, tx_frame_sync_dir, rx_hf_clock_dir, tx_hf_clock_dir;
	reg        tx_bit_clock_dir, network_mode, out_flag_one, rx_fs_gen, tx_fs_gen;
	reg        tx_bclk_gen, slot_strobe, tx_buf_enable, link_on;
	reg  [3:0] rx_hf_div, tx_hf_div;
	reg  [9:0] port_mode;
	reg  [4:0] port_out, drv_en, drv_val;
	reg  [1:0] hf_q;
	wire       rx_hf_tick, tx_hf_tick, rx_frame_event, tx_frame_event, tx_bclk_rise;
	wire       rx_bclk_rise, in_flag_one, rx_hf_clock_pin_out, rx_hf_clock_pin_oe;
	wire       tx_hf_clock_pin_out, tx_hf_clock_pin_oe, rx_frame_sync_pin_out;
	wire       rx_frame_sync_pin_oe, tx_frame_sync_pin_out, tx_frame_sync_pin_oe;
	wire       tx_bit_clock_pin_out, tx_bit_clock_pin_oe;
	wire [4:0] port_in, pin_v;
	wire [4:0] oe_v = {tx_bit_clock_pin_oe, tx_frame_sync_pin_oe, rx_frame_sync_pin_oe,
		tx_hf_clock_pin_oe, rx_hf_clock_pin_oe};
	wire [4:0] out_v = {tx_bit_clock_pin_out, tx_frame_sync_pin_out, rx_frame_sync_pin_out,
		tx_hf_clock_pin_out, rx_hf_clock_pin_out};
	wire [7:0] ev = {tx_hf_clock_pin_out != hf_q[1], rx_hf_clock_pin_out != hf_q[0],
		rx_bclk_rise, tx_bclk_rise, tx_frame_event, rx_frame_event, tx_hf_tick, rx_hf_tick};
	integer    cnt [0:7];
	integer    i, k, miscompares, checks_done;
	asp_pin_mux i_dut (.clock, .rstn, .ce, .serial_use, .sync_mode_select,
		.tx_buffer_enable_select, .rx_frame_sync_dir, .tx_frame_sync_dir, .rx_hf_clock_dir,
		.tx_hf_clock_dir, .tx_bit_clock_dir, .network_mode, .out_flag_one, .rx_hf_div,
		.tx_hf_div, .port_mode, .port_out, .rx_fs_gen, .tx_fs_gen, .tx_bclk_gen, .slot_strobe,
		.tx_buf_enable, .rx_hf_tick, .tx_hf_tick, .rx_frame_event, .tx_frame_event,
		.tx_bclk_rise, .rx_bclk_rise, .in_flag_one, .port_in, .rx_hf_clock_pin_in(pin_v[0]),
		.rx_hf_clock_pin_out, .rx_hf_clock_pin_oe, .tx_hf_clock_pin_in(pin_v[1]),
		.tx_hf_clock_pin_out, .tx_hf_clock_pin_oe, .rx_frame_sync_pin_in(pin_v[2]),
		.rx_frame_sync_pin_out, .rx_frame_sync_pin_oe, .tx_frame_sync_pin_in(pin_v[3]),
		.tx_frame_sync_pin_out, .tx_frame_sync_pin_oe, .tx_bit_clock_pin_in(pin_v[4]),
		.tx_bit_clock_pin_out, .tx_bit_clock_pin_oe);
	asp_codec_model i_codec (.link_on, .drv_en, .drv_val, .oe(oe_v), .dout(out_v), .pin(pin_v));
	// Count event pulses and hf toggles
	always @(posedge clock) begin
		hf_q <= {tx_hf_clock_pin_out, rx_hf_clock_pin_out};
		for (i = 0; i < 8; i = i + 1)
			cnt[i] <= clr ? 0 : cnt[i] + ev[i];
	end
	initial begin
		clock = 1'b0;
		forever #25 clock = ~clock;
	end
	// ==========================================================================
	// Shared tasks
	task tk(input integer n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	// Four settling cycles keep stale pulses out
	task clear_counts;
		clr = 1'b1;
		tk(4);
		clr = 1'b0;
	endtask
	task chk(input string name, input logic [7:0] seen, exp);
		checks_done = checks_done + 1;
		if (seen !== exp) begin
			miscompares = miscompares + 1;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task rng(input string name, input integer v, lo, hi);
		chk(name, {7'h00, v >= lo && v <= hi}, 8'h01);
	endtask
	task complete_run;
		$display("comparisons %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// ==========================================================================
	// Scenarios
	task t_reset;
		rstn = 1'b0;
		tk(6);
		chk("pin enables", {3'h0, oe_v}, 8'h00);
		chk("port inputs", {3'h0, port_in}, 8'h00);
		rstn = 1'b1;
		$display("test reset done");
	endtask
	// Each pin in modes off, in, out and spare 3 (off)
	task t_port;
		{serial_use, drv_en, drv_val, port_out} = {1'b0, 5'h1F, 5'h15, 5'h0A};
		for (k = 0; k < 4; k = k + 1) begin
			port_mode = {5{k[1:0]}};
			tk(3);
			chk("port enables", {3'h0, oe_v}, (k == 2) ? 8'h1F : 8'h00);
			chk("port outputs", {3'h0, out_v}, (k == 2) ? 8'h0A : 8'h00);
			chk("port inputs", {3'h0, port_in}, (k == 1) ? 8'h15 : 8'h00);
		end
		$display("test port done");
	endtask
	task t_hf;
		{serial_use, port_mode, drv_en, link_on, rx_hf_clock_dir, tx_hf_clock_dir} = 19'h40004;
		clear_counts;
		tk(80);
		rng("rx hf ticks", cnt[0], 32'h9, 32'hB);
		rng("tx hf ticks", cnt[1], 32'h9, 32'hB);
		{link_on, rx_hf_clock_dir, tx_hf_clock_dir, rx_hf_div, tx_hf_div} = 11'h321;
		clear_counts;
		tk(60);
		chk("hf pin enables", {6'h00, oe_v[1:0]}, 8'h03);
		rng("rx hf toggles", cnt[6], 32'h13, 32'h15);
		rng("tx hf toggles", cnt[7], 32'h1D, 32'h1F);
		$display("test hf clock done");
	endtask
	// Frame and bit clock inputs, async then sync
	task t_frame;
		{rx_hf_clock_dir, tx_hf_clock_dir, drv_en, drv_val} = {2'b11, 5'h1C, 5'h00};
		for (k = 0; k < 2; k = k + 1) begin
			{sync_mode_select, rx_frame_sync_dir, tx_frame_sync_dir} = {k[0], 2'b00};
			clear_counts;
			repeat (4) begin
				drv_val = 5'h1C;
				tk(4);
				drv_val = 5'h00;
				tk(4);
			end
			tk(4);
			rng("rx frame events", cnt[2], 32'h4, 32'h4);
			rng("tx frame events", cnt[3], 32'h4, 32'h4);
			rng("tx bit clock rises", cnt[4], 32'h4, 32'h4);
			rng("rx bit clock rises", cnt[5], 4 * k, 4 * k);
		end
		$display("test frame done");
	endtask
	task t_flag;
		{tx_buffer_enable_select, rx_frame_sync_dir, tx_frame_sync_dir} = 3'b011;
		{network_mode, out_flag_one, drv_en} = {2'b01, 5'h00};
		tk(3);
		tx_fs_gen = 1'b1;
		tk(1);
		{tx_fs_gen, network_mode, out_flag_one} = 3'b010;
		tk(3);
		chk("flag after frame", {6'h00, rx_frame_sync_pin_oe, rx_frame_sync_pin_out}, 8'h03);
		chk("tx frame pin enable", {7'h00, tx_frame_sync_pin_oe}, 8'h01);
		slot_strobe = 1'b1;
		tk(1);
		slot_strobe = 1'b0;
		tk(3);
		chk("flag after slot", {6'h00, rx_frame_sync_pin_oe, rx_frame_sync_pin_out}, 8'h02);
		for (k = 0; k < 2; k = k + 1) begin
			{rx_frame_sync_dir, drv_en, drv_val} = {1'b0, 5'h04, 2'h0, k[0], 2'h0};
			tk(5);
			slot_strobe = 1'b1;
			tk(1);
			slot_strobe = 1'b0;
			tk(2);
			chk("input flag", {6'h00, rx_frame_sync_pin_oe, in_flag_one}, {7'h00, k[0]});
		end
		{tx_buffer_enable_select, rx_frame_sync_dir, tx_buf_enable} = 3'b111;
		tk(3);
		chk("buffer enable", {6'h00, rx_frame_sync_pin_oe, rx_frame_sync_pin_out}, 8'h03);
		$display("test flag done");
	endtask
	// ==========================================================================
	// Main sequence; ce stays high
	initial begin
		{rstn, ce, clr, serial_use, sync_mode_select, tx_buffer_enable_select} = 6'b011000;
		{rx_frame_sync_dir, tx_frame_sync_dir, rx_hf_clock_dir, tx_hf_clock_dir} = 4'h0;
		{tx_bit_clock_dir, network_mode, out_flag_one, rx_fs_gen, tx_fs_gen} = 5'h00;
		{tx_bclk_gen, slot_strobe, tx_buf_enable, link_on, rx_hf_div, tx_hf_div} = 12'h000;
		{port_mode, port_out, drv_en, drv_val} = 25'h0000000;
		{miscompares, checks_done} = 64'h0;
		t_reset;
		tk(2);
		t_port;
		t_hf;
		t_frame;
		t_flag;
		t_reset;
		complete_run;
	end
endmodule
